// ==== logic/qrg_pkg.sv ====
// Package: constants and types for the quad read / command guard block
package qrg_pkg;
  localparam int          CMD_W          = 8;
  localparam int          BIT_CNT_W      = 16;
  localparam logic [2:0]  BYTE_MASK      = 3'h7;
  localparam int          LAT_HI         = 7;
  localparam int          LAT_LO         = 6;
  localparam int          QUAD_EN_BIT    = 1;
  localparam logic [7:0]  CFG_RESET      = 8'h00;
  // Instruction codes
  localparam logic [7:0]  OP_READ        = 8'h03;
  localparam logic [7:0]  OP_QOUT_READ   = 8'h6B;
  localparam logic [7:0]  OP_QIO_READ    = 8'hEB;
  localparam logic [7:0]  OP_QPAGE_WRITE = 8'h32;
  localparam logic [7:0]  OP_PAGE_WRITE  = 8'h02;
  localparam logic [7:0]  OP_SECT_ERASE  = 8'hD8;
  localparam logic [7:0]  OP_BULK_ERASE  = 8'h60;
  localparam logic [7:0]  OP_REG_WRITE   = 8'h01;
  localparam int          ADDR_BITS      = 24;
  localparam logic [3:0]  QIO_ADDR_CYC   = 4'h6;
  // Power-on initialisation time
  localparam int          POR_TIME_US    = 300;
  localparam int          CLK_MHZ        = 50;
  localparam int          POR_CYCLES     = POR_TIME_US * CLK_MHZ;
  localparam logic [1:0]  SYNC_RST       = 2'h0;

  typedef enum logic [2:0] {
    QRG_IDLE   = 3'b000,
    QRG_OPCODE = 3'b001,
    QRG_ADDR   = 3'b010,
    QRG_MODE   = 3'b011,
    QRG_LAT    = 3'b100,
    QRG_QOUT   = 3'b101,
    QRG_SINK   = 3'b110
  } qrg_state_type;

  // Mode and dummy cycle counts for one read instruction type
  typedef struct packed {
    logic [3:0] mode_cyc;
    logic [3:0] lat_cyc;
  } qrg_lat_type;

  // Quad data line triple: input, output, output enable (low = drive)
  typedef struct packed {
    logic [3:0] din;
    logic [3:0] dout;
    logic [3:0] oe_n;
  } qrg_quad_type;

  // Command accepted by the guard, handed to the system side
  typedef struct packed {
    logic [7:0] opcode;
    logic [15:0] clk_count;
  } qrg_cmd_type;
endpackage

// ==== logic/qrg_guard.sv ====
// Quad read output phase, latency selection and command acceptance guard
// Notes on behaviour
// [RQ1] Quad output phase drives all four data lines, four bits per clock.
// [RQ2] Quad output phase persists until chip select is released.
// [RQ3] Host keeps reset high and chip select low during quad output.
// [RQ4] Latency code comes from configuration register bits 7 and 6.
// [RQ5] Latency code sets mode and dummy cycle counts per instruction type.
// [RQ6] Quad enable set makes hold and write-protect inputs ignored.
// [RQ7] Quad write and quad reads accepted only with quad enable set.
// [RQ8] No command accepted before power-on initialisation completes.
// [RQ9] Commands ignored while supply-below-cutoff is active.
// [RQ10] Program, erase, register write need clock count multiple of eight.
// [RQ11] Failing count discards command silently, no error flag.
// [RQ12] Quad enable clear: hold low pauses command like a stopped clock.
// [RQ13] Host releases data lines by end of last latency cycle.
// [RQ14] Latency code to cycle counts mapping held in a parameter table.
`timescale 1ns/1ns
module qrg_guard #(
  parameter int                  POR_CYC  = qrg_pkg::POR_CYCLES,
  parameter qrg_pkg::qrg_lat_type QO_TAB [4] = '{'{4'h0,4'h8}, '{4'h0,4'h8},
                                                 '{4'h0,4'h8}, '{4'h0,4'h0}},
  parameter qrg_pkg::qrg_lat_type QIO_TAB [4] = '{'{4'h2,4'h4}, '{4'h2,4'h4},
                                                  '{4'h2,4'h4}, '{4'h2,4'h1}}
) (
  input  wire logic                 clk_sys,
  input  wire logic                 rst_n,
  input  wire logic                 clk_en,
  input  wire logic                 sck,
  input  wire logic                 cs_n,
  input  wire logic                 reset_pin_n,
  input  wire logic                 supply_low,
  input  wire logic [7:0]           config_register,
  input  wire logic [3:0]           din,
  output logic      [3:0]           dout,
  output logic      [3:0]           oe_n,
  input  wire logic [3:0]           rd_nibble,
  output logic                      rd_take,
  output qrg_pkg::qrg_cmd_type      cmd_out,
  output logic                      cmd_valid,
  output logic                      por_done,
  output logic                      hold_active,
  output logic                      wp_active
);
  // ---------------- System domain: power-on and crossings ----------------
  logic [$clog2(POR_CYC+1)-1:0] por_q, por_d;
  logic                         por_done_d, por_done_q;
  logic [1:0]                   low_s_q, ready_s_q, tog_s_q;
  logic                         tog_seen_q, tog_seen_d, cmd_valid_d, cmd_valid_q;
  qrg_pkg::qrg_cmd_type         cmd_q, cmd_d;

  always_comb begin
    por_d      = por_q;
    por_done_d = por_done_q;
    if (por_q != POR_CYC[$bits(por_q)-1:0]) begin
      por_d = por_q + 1'b1;
    end else begin
      por_done_d = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      por_q      <= '0;
      por_done_q <= 1'b0;
    end else if (clk_en) begin
      por_q      <= por_d;
      por_done_q <= por_done_d;
    end
  end
  assign por_done = por_done_q;

  // Link-side toggle marks an accepted command; payload is stable by then
  logic       acc_tog_q, acc_tog_d;
  qrg_pkg::qrg_cmd_type lk_cmd_q, lk_cmd_d;

  always_comb begin
    tog_seen_d  = tog_s_q[1];
    cmd_valid_d = tog_s_q[1] != tog_seen_q;
    cmd_d       = cmd_valid_d ? lk_cmd_q : cmd_q;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      low_s_q     <= qrg_pkg::SYNC_RST;
      ready_s_q   <= qrg_pkg::SYNC_RST;
      tog_s_q     <= qrg_pkg::SYNC_RST;
      tog_seen_q  <= 1'b0;
      cmd_valid_q <= 1'b0;
      cmd_q       <= '0;
    end else if (clk_en) begin
      low_s_q     <= {low_s_q[0], supply_low};
      ready_s_q   <= {ready_s_q[0], por_done_q};
      tog_s_q     <= {tog_s_q[0], acc_tog_q};
      tog_seen_q  <= tog_seen_d;
      cmd_valid_q <= cmd_valid_d;
      cmd_q       <= cmd_d;
    end
  end
  assign cmd_valid = cmd_valid_q;
  assign cmd_out   = cmd_q;

  // ---------------- Link domain: runs on sck and on chip select rising ----------------
  logic [1:0] lk_ready_q, lk_low_q, lk_cfg_sel;
  logic [7:0] lk_cfg_s0_q, lk_cfg_q;
  always_ff @(posedge sck or negedge rst_n) begin
    if (!rst_n) begin
      lk_ready_q  <= qrg_pkg::SYNC_RST;
      lk_low_q    <= qrg_pkg::SYNC_RST;
      lk_cfg_s0_q <= qrg_pkg::CFG_RESET;
      lk_cfg_q    <= qrg_pkg::CFG_RESET;
    end else begin
      lk_ready_q  <= {lk_ready_q[0], ready_s_q[1]};
      lk_low_q    <= {lk_low_q[0], low_s_q[1]};
      lk_cfg_s0_q <= config_register;
      lk_cfg_q    <= lk_cfg_s0_q;
    end
  end

  wire quad_en  = lk_cfg_q[qrg_pkg::QUAD_EN_BIT];
  assign lk_cfg_sel = lk_cfg_q[qrg_pkg::LAT_HI:qrg_pkg::LAT_LO]; // RQ4
  // Hold and write protect only apply outside quad mode
  assign hold_active = !quad_en && !din[3] && !cs_n; // RQ6 RQ12
  assign wp_active   = !quad_en && !din[2]; // RQ6
  // Paused cycles act as though the clock were low
  wire   step        = !hold_active; // RQ12
  // Host-side reset pin holds the interface idle
  wire   sel         = !cs_n && reset_pin_n;

  qrg_pkg::qrg_state_type st_q, st_d;
  logic [15:0] cnt_q, cnt_d;
  logic [7:0]  op_q, op_d;
  logic [4:0]  sub_q, sub_d;
  logic [3:0]  lat_q, lat_d;
  qrg_pkg::qrg_lat_type sel_lat;

  function automatic logic is_guarded(input logic [7:0] op);
    return op == qrg_pkg::OP_PAGE_WRITE || op == qrg_pkg::OP_QPAGE_WRITE ||
           op == qrg_pkg::OP_SECT_ERASE || op == qrg_pkg::OP_BULK_ERASE ||
           op == qrg_pkg::OP_REG_WRITE;
  endfunction

  function automatic logic is_quad(input logic [7:0] op);
    return op == qrg_pkg::OP_QPAGE_WRITE || op == qrg_pkg::OP_QOUT_READ ||
           op == qrg_pkg::OP_QIO_READ;
  endfunction

  always_comb begin
    sel_lat = (op_q == qrg_pkg::OP_QIO_READ) ? QIO_TAB[lk_cfg_sel]
                                              : QO_TAB[lk_cfg_sel]; // RQ5 RQ14
  end

  wire [7:0] op_next = {op_q[6:0], din[0]};
  wire       allowed = lk_ready_q[1] && !lk_low_q[1]; // RQ8 RQ9

  always_comb begin
    st_d      = st_q;
    cnt_d     = cnt_q;
    op_d      = op_q;
    sub_d     = sub_q;
    lat_d     = lat_q;
    unique case (st_q)
      qrg_pkg::QRG_IDLE: begin
        cnt_d = 16'h0001;
        op_d  = {7'h00, din[0]};
        sub_d = 5'h01;
        st_d  = allowed ? qrg_pkg::QRG_OPCODE : qrg_pkg::QRG_SINK; // RQ8 RQ9
      end
      qrg_pkg::QRG_OPCODE: begin
        cnt_d = cnt_q + 16'h0001;
        op_d  = op_next;
        sub_d = sub_q + 5'h01;
        if (sub_q == 5'h07) begin
          sub_d = '0;
          if (is_quad(op_next) && !quad_en) begin
            st_d = qrg_pkg::QRG_SINK; // RQ7
          end else if (op_next == qrg_pkg::OP_QOUT_READ ||
                       op_next == qrg_pkg::OP_QIO_READ) begin
            st_d = qrg_pkg::QRG_ADDR;
          end else begin
            st_d = qrg_pkg::QRG_SINK;
          end
        end
      end
      qrg_pkg::QRG_ADDR: begin
        sub_d = sub_q + 5'h01;
        if ((op_q == qrg_pkg::OP_QIO_READ && sub_q == 5'(qrg_pkg::QIO_ADDR_CYC - 1)) ||
            sub_q == 5'(qrg_pkg::ADDR_BITS - 1)) begin
          sub_d = '0;
          lat_d = sel_lat.lat_cyc;
          st_d  = sel_lat.mode_cyc != 4'h0 ? qrg_pkg::QRG_MODE :
                  sel_lat.lat_cyc != 4'h0 ? qrg_pkg::QRG_LAT : qrg_pkg::QRG_QOUT; // RQ5
        end
      end
      qrg_pkg::QRG_MODE: begin
        sub_d = sub_q + 5'h01;
        if (sub_q[3:0] == sel_lat.mode_cyc - 4'h1) begin
          st_d = lat_q != 4'h0 ? qrg_pkg::QRG_LAT : qrg_pkg::QRG_QOUT; // RQ5
        end
      end
      qrg_pkg::QRG_LAT: begin
        lat_d = lat_q - 4'h1;
        if (lat_q == 4'h1) begin
          st_d = qrg_pkg::QRG_QOUT; // RQ13
        end
      end
      qrg_pkg::QRG_QOUT: begin
        st_d = qrg_pkg::QRG_QOUT; // RQ2
      end
      qrg_pkg::QRG_SINK: begin
        cnt_d = cnt_q + 16'h0001;
      end
      default: st_d = qrg_pkg::QRG_IDLE;
    endcase
  end

  always_ff @(posedge sck or negedge rst_n) begin
    if (!rst_n) begin
      st_q  <= qrg_pkg::QRG_IDLE;
      cnt_q <= '0;
      op_q  <= '0;
      sub_q <= '0;
      lat_q <= '0;
    end else if (!sel) begin
      st_q <= qrg_pkg::QRG_IDLE; // RQ2 RQ3
      // Forget the opcode so a frame without clocks cannot accept it again
      op_q <= '0;
    end else if (step) begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
      op_q  <= op_d;
      sub_q <= sub_d;
      lat_q <= lat_d;
    end
  end

  // End of frame: chip select rising closes the guarded command check
  always_comb begin
    acc_tog_d = acc_tog_q;
    lk_cmd_d  = lk_cmd_q;
    if (is_guarded(op_q) && allowed && (cnt_q[2:0] & qrg_pkg::BYTE_MASK) == 3'h0 &&
        !(is_quad(op_q) && !quad_en)) begin
      acc_tog_d = !acc_tog_q; // RQ10
      lk_cmd_d  = '{opcode: op_q, clk_count: cnt_q};
    end
    // Otherwise discarded with nothing flagged: RQ11
  end

  always_ff @(posedge cs_n or negedge rst_n) begin
    if (!rst_n) begin
      acc_tog_q <= 1'b0;
      lk_cmd_q  <= '0;
    end else begin
      acc_tog_q <= acc_tog_d;
      lk_cmd_q  <= lk_cmd_d;
    end
  end

  // Output on falling edge so data is stable at the host's rising edge
  logic [3:0] dout_q, dout_d, oe_n_q, oe_n_d;
  logic       take_q, take_d;
  always_comb begin
    dout_d = dout_q;
    oe_n_d = 4'hF;
    take_d = 1'b0;
    if (sel && st_q == qrg_pkg::QRG_QOUT) begin
      dout_d = rd_nibble; // RQ1
      oe_n_d = 4'h0; // RQ1
      take_d = step;
    end
  end

  always_ff @(negedge sck or negedge rst_n) begin
    if (!rst_n) begin
      dout_q <= '0;
      oe_n_q <= 4'hF;
      take_q <= 1'b0;
    end else begin
      dout_q <= dout_d;
      oe_n_q <= oe_n_d;
      take_q <= take_d;
    end
  end
  assign dout    = dout_q;
  assign oe_n    = cs_n ? 4'hF : oe_n_q;
  assign rd_take = take_q;

  qout_lines_a: assert property (@(posedge sck) disable iff (!rst_n)
    (st_q == qrg_pkg::QRG_QOUT && sel) |=> ##0 (cs_n || oe_n == 4'h0))
    else $error("quad output lines not all driven"); // RQ1
  qout_stays_a: assert property (@(posedge sck) disable iff (!rst_n)
    (st_q == qrg_pkg::QRG_QOUT && sel) |=> st_q == qrg_pkg::QRG_QOUT)
    else $error("quad output phase left while selected"); // RQ2
  quad_gate_a: assert property (@(posedge sck) disable iff (!rst_n)
    !quad_en |-> st_q != qrg_pkg::QRG_QOUT || $past(quad_en))
    else $error("quad read entered without quad enable"); // RQ7
  hold_off_a: assert property (@(posedge sck) disable iff (!rst_n)
    quad_en |-> !hold_active && !wp_active)
    else $error("hold or protect active in quad mode"); // RQ6
  lowsup_block_a: assert property (@(posedge sck) disable iff (!rst_n)
    (st_q == qrg_pkg::QRG_IDLE && sel && lk_low_q[1] && step) |=>
      st_q == qrg_pkg::QRG_SINK)
    else $error("command taken under low supply"); // RQ9
  por_block_a: assert property (@(posedge sck) disable iff (!rst_n)
    (st_q == qrg_pkg::QRG_IDLE && sel && !lk_ready_q[1] && step) |=>
      st_q == qrg_pkg::QRG_SINK)
    else $error("command taken before init"); // RQ8
  cnt_mult_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cmd_valid |-> cmd_out.clk_count[2:0] == 3'h0)
    else $error("guarded command with bad count"); // RQ10 RQ11
  hold_pause_a: assert property (@(posedge sck) disable iff (!rst_n)
    (hold_active && sel) |=> $stable(st_q) && $stable(cnt_q))
    else $error("state moved during hold"); // RQ12
  pin_reset_a: assert property (@(posedge sck) disable iff (!rst_n)
    !reset_pin_n |=> st_q == qrg_pkg::QRG_IDLE)
    else $error("interface not idle under reset pin"); // RQ3
endmodule

// ==== testbench/qrg_host.sv ====
// Host controller model driving serial clock, chip select and data lines
`timescale 1ns/1ns
module qrg_host (
  output logic       sck,
  output logic       cs_n,
  output logic [3:0] h_val,
  output logic [3:0] h_oe_n
);
  initial begin
    sck    = 1'b0;
    cs_n   = 1'b1;
    h_val  = 4'hD;
    h_oe_n = 4'h0;
  end
  // Deselected clocks let the synchronisers settle
  task automatic idle(input int n);
    repeat (n) begin
      rise();
      fall();
    end
  endtask
  task automatic rise();
    #8 sck = 1'b1;
  endtask
  task automatic fall();
    #7 sck = 1'b0;
  endtask
  // Shifts n bits MSB first on line 0
  task automatic send(input logic [39:0] v, input int n);
    cs_n   = 1'b0;
    h_oe_n = 4'h0;
    for (int i = n - 1; i >= 0; i--) begin
      h_val[0] = v[i];
      rise();
      fall();
    end
  endtask
  task automatic release_lines();
    h_oe_n = 4'hF;
  endtask
  task automatic deselect();
    #8 cs_n = 1'b1;
    h_oe_n = 4'h0;
  endtask
endmodule

// ==== testbench/tb_top.sv ====
// Self-checking bench for the quad read and command guard block
`timescale 1ns/1ns
module tb_top;
  localparam qrg_pkg::qrg_lat_type QO_TAB [4] = '{'{4'h0, 4'h1}, '{4'h0, 4'h2},
                                                 '{4'h0, 4'h3}, '{4'h0, 4'h4}};
  localparam qrg_pkg::qrg_lat_type QIO_TAB [4] = '{'{4'h2, 4'h3}, '{4'h1, 4'h1},
                                                  '{4'h2, 4'h2}, '{4'h3, 4'h4}};
  localparam logic [7:0] OPS [6] = '{qrg_pkg::OP_REG_WRITE, qrg_pkg::OP_PAGE_WRITE,
    qrg_pkg::OP_SECT_ERASE, qrg_pkg::OP_BULK_ERASE, qrg_pkg::OP_REG_WRITE,
    qrg_pkg::OP_PAGE_WRITE};
  localparam int LENS [6] = '{16, 40, 32, 8, 15, 33};
  logic                 clk_sys = 1'b0;
  logic                 rst_n = 1'b0;
  logic                 supply_low = 1'b0;
  logic                 clk_en = 1'b1;
  logic                 reset_pin_n = 1'b1;
  logic [7:0]           config_register = 8'h00;
  logic [3:0]           rd_nibble = 4'h0;
  logic [3:0]           junk = 4'h5;
  logic                 sck;
  logic                 cs_n;
  logic [3:0]           h_val;
  logic [3:0]           h_oe_n;
  logic [3:0]           din;
  logic [3:0]           dout;
  logic [3:0]           oe_n;
  logic                 rd_take;
  logic                 cmd_valid;
  logic                 por_done;
  logic                 hold_active;
  logic                 wp_active;
  qrg_pkg::qrg_cmd_type cmd_out;
  logic [23:0]          exp_q[$];
  int                   failures = 0;
  int                   checked = 0;
  int                   n;

  always #10 clk_sys = ~clk_sys;
  // Released lines show a changing pattern, never the last value
  always @(posedge sck) junk <= ~junk;
  for (genvar i = 0; i < 4; i++) begin : g_wire
    assign din[i] = !oe_n[i] ? dout[i] : !h_oe_n[i] ? h_val[i] : junk[i];
  end

  qrg_host host (.sck(sck), .cs_n(cs_n), .h_val(h_val), .h_oe_n(h_oe_n));

  qrg_guard #(.POR_CYC(40), .QO_TAB(QO_TAB), .QIO_TAB(QIO_TAB)) u_dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .sck(sck), .cs_n(cs_n),
    .reset_pin_n(reset_pin_n), .supply_low(supply_low), .config_register(config_register),
    .din(din), .dout(dout), .oe_n(oe_n), .rd_nibble(rd_nibble), .rd_take(rd_take),
    .cmd_out(cmd_out), .cmd_valid(cmd_valid), .por_done(por_done),
    .hold_active(hold_active), .wp_active(wp_active));

  task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic finish_test();
    if (failures == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(negedge clk_sys) begin
    if (cmd_valid === 1'b1) begin
      if (exp_q.size() == 0) check("cmd_unexpected", 24'h1, 24'h0);
      else check("cmd_out", cmd_out, exp_q.pop_front());
    end
  end

  task automatic cfg_set(input logic [7:0] v);
    @(posedge clk_sys);
    #2 config_register = v;
  endtask

  task automatic frame(input logic [7:0] op, input int len, input bit acc);
    host.idle(4);
    host.send({op, 32'hA5C3_5A3C} >> (40 - len), len);
    host.deselect();
    if (acc) exp_q.push_back({op, 16'(len)});
    repeat (10) @(posedge clk_sys);
  endtask

  task automatic quad_read(input logic [1:0] c, input bit qio);
    int                   cnt;
    int                   len;
    logic [3:0]           nib;
    logic [7:0]           op;
    qrg_pkg::qrg_lat_type t;
    t   = qio ? QIO_TAB[c] : QO_TAB[c];
    op  = qio ? qrg_pkg::OP_QIO_READ : qrg_pkg::OP_QOUT_READ;
    len = 8 + int'(t.mode_cyc) + (qio ? int'(qrg_pkg::QIO_ADDR_CYC) : qrg_pkg::ADDR_BITS);
    cfg_set({c, 6'h02});
    host.idle(4);
    host.send({op, 32'h3C5A_96E1} >> (40 - len), len);
    host.release_lines();
    cnt = 0;
    while (oe_n !== 4'h0 && cnt < 20) begin
      host.rise();
      host.fall();
      #1 cnt++;
    end
    check("lat_cycles", 24'(cnt), {20'h0, t.lat_cyc});
    if (cnt == 20) finish_test();
    repeat (6) begin
      nib = 4'($urandom);
      rd_nibble = nib;
      host.rise();
      host.fall();
      #1 check("dout", {20'h0, dout}, {20'h0, nib});
      check("oe_rd_take", {16'h0, oe_n, 3'h0, rd_take}, 24'h1);
    end
    host.deselect();
    #2 check("oe_after_cs", {20'h0, oe_n}, 24'hF);
    repeat (6) @(posedge clk_sys);
  endtask

  initial begin
    void'($urandom(32'hA6CF_B42C));
    fork
      host.idle(6);
      repeat (5) @(posedge clk_sys);
    join
    #2 rst_n = 1'b1;
    clk_en = 1'b0;
    check("por_early", {23'h0, por_done}, 24'h0);
    repeat (50) @(posedge clk_sys);
    #2 check("por_frozen", {23'h0, por_done}, 24'h0);
    clk_en = 1'b1;
    frame(qrg_pkg::OP_REG_WRITE, 16, 1'b0);
    n = 0;
    while (por_done !== 1'b1 && n < 100) begin
      @(posedge clk_sys);
      #2 n++;
    end
    if (n == 100) begin
      check("por_done", 24'h0, 24'h1);
      finish_test();
    end
    // Lets the ready indication cross into the link domain
    host.idle(4);
    for (int i = 0; i < 6; i++) frame(OPS[i], LENS[i], i < 4);
    @(posedge clk_sys);
    #2 supply_low = 1'b1;
    frame(qrg_pkg::OP_SECT_ERASE, 32, 1'b0);
    @(posedge clk_sys);
    #2 supply_low = 1'b0;
    frame(qrg_pkg::OP_QPAGE_WRITE, 40, 1'b0);
    // Held clocks inside a register write are not counted
    host.h_val[2] = 1'b0;
    host.idle(4);
    host.send(40'(qrg_pkg::OP_REG_WRITE), 8);
    host.h_val[3] = 1'b0;
    #1 check("hold_wp_off", {22'h0, hold_active, wp_active}, 24'h3);
    host.idle(3);
    host.h_val[3] = 1'b1;
    host.send(40'h5A, 8);
    host.deselect();
    exp_q.push_back({qrg_pkg::OP_REG_WRITE, 16'h0010});
    repeat (10) @(posedge clk_sys);
    #2 reset_pin_n = 1'b0;
    frame(qrg_pkg::OP_SECT_ERASE, 32, 1'b0);
    #2 reset_pin_n = 1'b1;
    // Quad read refused while quad enable is clear
    host.idle(4);
    host.send({qrg_pkg::OP_QOUT_READ, 32'h3C5A_96E1} >> 8, 32);
    host.release_lines();
    host.idle(6);
    #1 check("qor_gated", {20'h0, oe_n}, 24'hF);
    host.deselect();
    cfg_set(8'h02);
    host.h_val[3:2] = 2'b00;
    host.idle(4);
    #1 check("hold_wp_on", {22'h0, hold_active, wp_active}, 24'h0);
    // Hold and protect held low: the count must still reach 40
    frame(qrg_pkg::OP_QPAGE_WRITE, 40, 1'b1);
    host.h_val[3:2] = 2'b11;
    for (int c = 0; c < 8; c++) quad_read(2'(c), c >= 4);
    repeat (10) @(posedge clk_sys);
    check("pending", 24'(exp_q.size()), 24'h0);
    finish_test();
  end
endmodule
